// ==== core/serial_port_map.svh ====
// Register offsets, field positions and reset values of the serial port
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// Byte offsets on the register bus
`define SP_CTRL_OFS      12'h000
`define SP_BUF_OFS       12'h004
`define SP_BAUD_OFS      12'h008

// Control word fields
`define SP_MODE_LSB      0
`define SP_MODE_MSB      1
`define SP_RATE32_BIT    2
`define SP_FILTER_BIT    3
`define SP_TXNINTH_BIT   4
`define SP_RXNINTH_BIT   5
`define SP_TXDONE_BIT    6
`define SP_RXDONE_BIT    7
`define SP_RXBUSY_BIT    8
`define SP_TXBUSY_BIT    9

// Reset values
`define SP_CTRL_RST      5'h01
`define SP_BAUD_RST      16'h0000
`define SP_BUF_RST       8'h00

// Oversampling counter states
`define SP_LAST_PHASE    4'hf
`define SP_SAMPLE_A      4'h7
`define SP_SAMPLE_B      4'h8
`define SP_SAMPLE_C      4'h9

`endif

// ==== core/serial_port_pkg.sv ====
// Types shared by the serial port design
package serial_port_pkg;

    typedef enum logic [1:0] {
        MODE_ZERO,
        MODE_ONE,
        MODE_TWO,
        MODE_THREE
    } sp_mode_t;

    typedef enum {
        TX_IDLE,
        TX_WAIT,
        TX_START,
        TX_DATA
    } tx_state_t;

    typedef enum {
        RX_HUNT,
        RX_BITS,
        RX_STOP
    } rx_state_t;

    // Software-owned control fields
    typedef struct packed {
        logic       txNinth;
        logic       filter;
        logic       rate32;
        sp_mode_t   mode;
    } sp_ctrl_t;

endpackage

// ==== core/serial_port_modes_async.sv ====
// Asynchronous serial port, frame modes one to three, with APB registers
//
// What this block does
// - Mode one frame: low start, eight data LSB first, high stop.
// - Mode one accepts only if done flag clear and filter off or stop 1.
// - Mode one accept: stop to ninth flag, byte to buffer, set done.
// - Mode one: after final shift, hunt for falling edge again.
// - Modes two/three frame: start, eight data, ninth bit, stop.
// - Ninth transmit bit from software flag; received one to flag.
// - Mode two rate is clock over 16 or over 32.
// - Mode three rate comes from the reload timer overflow.
// - Buffer write requests sending and loads ninth shift position.
// - Sending starts after next divide-by-16 rollover.
// - Start bit, data enable one bit later, first shift one more.
// - Modes two/three: first shift inserts stop bit on top, later shifts zeros.
// - Ninth bit out with stop beside: last shift, stop, set done.
// - Receive line sampled at sixteen times bit rate for edge.
// - Falling edge resets counter and loads all ones into shifter.
// - Samples at states 7, 8, 9; majority of three wins.
// - Start voted high: receiver resets and hunts again.
// - Bits enter from right; start at left means final shift.
// - Modes two/three accept if done clear and filter off or ninth 1.
// - Accept: ninth to flag, byte to buffer, set done; else lost.
// - Modes two/three hunt again one bit time after final shift.
module serial_port_modes_async
    import serial_port_pkg::*;
#(
    parameter int BAUD_W = 16
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd
);
`include "serial_port_map.svh"

    // Refuse divisor widths the prescaler cannot hold
    if (BAUD_W < 1 || BAUD_W > 16) begin
        $error("BAUD_W must be 1 to 16");
    end

    // Majority of three samples
    function automatic logic vote3(input logic a, input logic b,
                                   input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // Bit order reversal for received byte
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    // Registers
    sp_ctrl_t          ctrl_ff;
    logic [BAUD_W-1:0] baudDiv_ff;
    logic [BAUD_W-1:0] preCnt_ff;
    logic              half_ff;
    logic [7:0]        rxBuf_ff;
    logic              rxNinth_ff;
    logic              txDone_ff;
    logic              rxDone_ff;
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic              rxMeta_ff;
    logic              rxSync_ff;
    logic              rxPrev_ff;
    tx_state_t         txState_ff;
    logic [3:0]        txCnt_ff;
    logic [8:0]        txShift_ff;
    logic              firstShift_ff;
    logic              txd_ff;
    rx_state_t         rxState_ff;
    logic [3:0]        rxCnt_ff;
    logic [8:0]        rxShift_ff;
    logic              firstBit_ff;
    logic              sampA_ff;
    logic              sampB_ff;

    // Bus decode
    wire setupPh  = psel & ~penable;
    wire accessOk = psel & penable & pready_ff;
    wire hitCtrl  = (paddr == `SP_CTRL_OFS);
    wire hitBuf   = (paddr == `SP_BUF_OFS);
    wire hitBaud  = (paddr == `SP_BAUD_OFS);
    wire mapped   = hitCtrl | hitBuf | hitBaud;
    wire wrCtrl   = accessOk & pwrite & hitCtrl;
    wire wrBuf    = accessOk & pwrite & hitBuf;
    wire wrBaud   = accessOk & pwrite & hitBaud;

    // Oversampling tick source
    wire modeTwo   = (ctrl_ff.mode == MODE_TWO);
    wire modeOne   = (ctrl_ff.mode == MODE_ONE)
                   | (ctrl_ff.mode == MODE_ZERO);
    wire timerOvf  = (preCnt_ff == baudDiv_ff);
    wire tick      = modeTwo ? (~ctrl_ff.rate32 | half_ff)
                             : timerOvf;
    wire [BAUD_W-1:0] nxt_preCnt = timerOvf ? '0
                                 : preCnt_ff + BAUD_W'(1);

    // Read data word
    wire [31:0] ctrlWord = {22'h0,
                            (txState_ff != TX_IDLE),
                            (rxState_ff != RX_HUNT),
                            rxDone_ff, txDone_ff, rxNinth_ff,
                            ctrl_ff.txNinth, ctrl_ff.filter,
                            ctrl_ff.rate32, ctrl_ff.mode};
    wire [31:0] nxt_prdata = hitCtrl ? ctrlWord
                           : hitBuf  ? {24'h000000, rxBuf_ff}
                           : hitBaud ? 32'(baudDiv_ff)
                           : 32'h00000000;

    // Transmit timing
    wire txRoll = tick & (txCnt_ff == `SP_LAST_PHASE);
    wire txEnd  = ~firstShift_ff
                & (txShift_ff[8:1] == 8'h01);
    wire insBit = firstShift_ff & ~modeOne;
    wire ninthLoad = modeOne ? 1'b1
                             : ctrl_ff.txNinth;

    tx_state_t  nxt_txState;
    logic [8:0] nxt_txShift;
    logic       nxt_firstShift;
    logic       txDoneSet;
    logic       nxt_txd;

    // Transmit control
    always_comb begin
        nxt_txState    = txState_ff;
        nxt_txShift    = txShift_ff;
        nxt_firstShift = firstShift_ff;
        txDoneSet      = 1'b0;
        case (txState_ff)
            TX_IDLE: begin
            end
            TX_WAIT: begin
                if (txRoll) begin
                    nxt_txState = TX_START;
                end
            end
            TX_START: begin
                if (txRoll) begin
                    nxt_txState = TX_DATA;
                end
            end
            TX_DATA: begin
                if (txRoll) begin
                    nxt_txShift    = {insBit, txShift_ff[8:1]};
                    nxt_firstShift = 1'b0;
                    if (txEnd) begin
                        nxt_txState = TX_IDLE;
                        txDoneSet   = 1'b1;
                    end
                end
            end
            default: begin
                nxt_txState = TX_IDLE;
            end
        endcase
        if (wrBuf) begin
            nxt_txState    = TX_WAIT;
            nxt_txShift    = {ninthLoad, pwdata[7:0]};
            nxt_firstShift = 1'b1;
        end
        case (nxt_txState)
            TX_START: nxt_txd = 1'b0;
            TX_DATA:  nxt_txd = nxt_txShift[0];
            default:  nxt_txd = 1'b1;
        endcase
    end

    // Receive timing
    wire rxLine  = rxSync_ff;
    wire fallEdg = tick & rxPrev_ff & ~rxLine;
    wire atC     = tick & (rxCnt_ff == `SP_SAMPLE_C);
    wire voted   = vote3(sampA_ff, sampB_ff, rxLine);
    wire finalSh = ~rxShift_ff[8];
    wire accept  = ~rxDone_ff
                 & (~ctrl_ff.filter | voted);

    rx_state_t  nxt_rxState;
    logic [8:0] nxt_rxShift;
    logic       nxt_firstBit;
    logic       rxLoad;

    // Receive control
    always_comb begin
        nxt_rxState  = rxState_ff;
        nxt_rxShift  = rxShift_ff;
        nxt_firstBit = firstBit_ff;
        rxLoad       = 1'b0;
        case (rxState_ff)
            RX_HUNT: begin
                if (fallEdg) begin
                    nxt_rxState  = RX_BITS;
                    nxt_rxShift  = 9'h1ff;
                    nxt_firstBit = 1'b1;
                end
            end
            RX_BITS: begin
                if (atC) begin
                    nxt_firstBit = 1'b0;
                    if (firstBit_ff & voted) begin
                        nxt_rxState = RX_HUNT;
                    end else if (finalSh) begin
                        nxt_rxShift = {rxShift_ff[7:0], voted};
                        rxLoad      = accept;
                        nxt_rxState = modeOne ? RX_HUNT
                                              : RX_STOP;
                    end else begin
                        nxt_rxShift = {rxShift_ff[7:0], voted};
                    end
                end
            end
            RX_STOP: begin
                if (atC) begin
                    nxt_rxState = RX_HUNT;
                end
            end
            default: begin
                nxt_rxState = RX_HUNT;
            end
        endcase
    end

    // Flags: hardware set wins over software write
    wire nxt_txDone = txDoneSet
                    | (wrCtrl ? pwdata[`SP_TXDONE_BIT] : txDone_ff);
    wire nxt_rxDone = rxLoad
                    | (wrCtrl ? pwdata[`SP_RXDONE_BIT] : rxDone_ff);

    // Bus slave outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setupPh;
            pslverr_ff <= setupPh & ~mapped;
            if (setupPh) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff    <= sp_ctrl_t'(`SP_CTRL_RST);
            baudDiv_ff <= BAUD_W'(`SP_BAUD_RST);
        end else begin
            if (wrCtrl) begin
                ctrl_ff <= sp_ctrl_t'(pwdata[4:0]);
            end
            if (wrBaud) begin
                baudDiv_ff <= pwdata[BAUD_W-1:0];
            end
        end
    end

    // Status flags and received data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txDone_ff  <= 1'b0;
            rxDone_ff  <= 1'b0;
            rxNinth_ff <= 1'b0;
            rxBuf_ff   <= `SP_BUF_RST;
        end else begin
            txDone_ff <= nxt_txDone;
            rxDone_ff <= nxt_rxDone;
            if (rxLoad) begin
                rxNinth_ff <= voted;
                rxBuf_ff   <= rev8(rxShift_ff[7:0]);
            end
        end
    end

    // Bit-rate prescaler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preCnt_ff <= '0;
            half_ff   <= 1'b0;
        end else begin
            preCnt_ff <= nxt_preCnt;
            half_ff   <= ~half_ff;
        end
    end

    // Receive line synchroniser and edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxMeta_ff <= 1'b1;
            rxSync_ff <= 1'b1;
            rxPrev_ff <= 1'b1;
        end else begin
            rxMeta_ff <= rxd;
            rxSync_ff <= rxMeta_ff;
            if (tick) begin
                rxPrev_ff <= rxLine;
            end
        end
    end

    // Transmit state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txState_ff    <= TX_IDLE;
            txCnt_ff      <= 4'h0;
            txShift_ff    <= 9'h1ff;
            firstShift_ff <= 1'b0;
            txd_ff        <= 1'b1;
        end else begin
            txState_ff    <= nxt_txState;
            txShift_ff    <= nxt_txShift;
            firstShift_ff <= nxt_firstShift;
            txd_ff        <= nxt_txd;
            if (tick) begin
                txCnt_ff <= txCnt_ff + 4'h1;
            end
        end
    end

    // Receive state and bit samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxState_ff  <= RX_HUNT;
            rxCnt_ff    <= 4'h0;
            rxShift_ff  <= 9'h1ff;
            firstBit_ff <= 1'b0;
            sampA_ff    <= 1'b1;
            sampB_ff    <= 1'b1;
        end else begin
            rxState_ff  <= nxt_rxState;
            rxShift_ff  <= nxt_rxShift;
            firstBit_ff <= nxt_firstBit;
            if (fallEdg && rxState_ff == RX_HUNT) begin
                rxCnt_ff <= 4'h0;
            end else if (tick) begin
                rxCnt_ff <= rxCnt_ff + 4'h1;
            end
            if (tick && rxCnt_ff == `SP_SAMPLE_A) begin
                sampA_ff <= rxLine;
            end
            if (tick && rxCnt_ff == `SP_SAMPLE_B) begin
                sampB_ff <= rxLine;
            end
        end
    end

    // Outputs straight from flip-flops
    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign txd     = txd_ff;

endmodule

// ==== verif/serial_port_asserts.sv ====
// Checker of bus answers and transmit line timing
`include "serial_port_map.svh"
module serial_port_asserts
    import serial_port_pkg::*;
#(
    parameter int BAUD_W = 16
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxd,
    input wire logic        txd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] baud_ff;
    logic [2:0]  cfg_ff;
    logic [20:0] lowCnt_ff;
    logic [20:0] waitCnt_ff;
    // Write completion, bit length and run counters
    wire         wrDone      = psel && penable && pready && pwrite;
    wire         bufWr       = wrDone && paddr == `SP_BUF_OFS;
    wire         mapped      = paddr inside {12'h000, 12'h004, 12'h008};
    wire  [20:0] bitClks     = cfg_ff[1:0] == 2'h2 ?
                               (cfg_ff[2] ? 21'h20 : 21'h10) :
                               (21'(baud_ff) + 21'h1) << 4;
    wire  [20:0] nxt_lowCnt  = txd ? 21'h0 : lowCnt_ff + 21'h1;
    wire  [20:0] nxt_waitCnt = bufWr ? 21'h1 :
                               (txd && waitCnt_ff != 21'h0) ?
                               waitCnt_ff + 21'h1 : 21'h0;
    // Shadow of rate settings and run counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baud_ff    <= 16'h0000;
            cfg_ff     <= 3'h1;
            lowCnt_ff  <= 21'h0;
            waitCnt_ff <= 21'h0;
        end else begin
            lowCnt_ff  <= nxt_lowCnt;
            waitCnt_ff <= nxt_waitCnt;
            if (wrDone && paddr == `SP_BAUD_OFS) baud_ff <= pwdata[15:0];
            if (wrDone && paddr == `SP_CTRL_OFS) cfg_ff <= pwdata[2:0];
        end
    end
    property p_idleAfterReset;
        $fell(rst) |-> txd;
    endproperty
    a_idleAfterReset: assert property (p_idleAfterReset)
        else $error("txd low right after reset");
    property p_lowRunWhole;
        $rose(txd) |-> lowCnt_ff % bitClks == 21'h0;
    endproperty
    a_lowRunWhole: assert property (p_lowRunWhole)
        else $error("low run on txd not whole bit times");
    property p_lowMax;
        !txd |-> lowCnt_ff < (bitClks << 3) + (bitClks << 1);
    endproperty
    a_lowMax: assert property (p_lowMax)
        else $error("txd low longer than a frame");
    property p_startAligned;
        waitCnt_ff <= bitClks + 21'h8;
    endproperty
    a_startAligned: assert property (p_startAligned)
        else $error("start bit late after buffer write");
    property p_readyAfterSetup;
        psel && !penable |=> pready;
    endproperty
    a_readyAfterSetup: assert property (p_readyAfterSetup)
        else $error("no ready after setup");
    property p_readyPulse;
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse)
        else $error("ready longer than one cycle");
    property p_errUnmapped;
        pready |-> pslverr == !mapped;
    endproperty
    a_errUnmapped: assert property (p_errUnmapped)
        else $error("error flag wrong for address");
    property p_zeroUnmapped;
        pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_zeroUnmapped: assert property (p_zeroUnmapped)
        else $error("unmapped read not zero");
    c_multiBitLow: cover property ($rose(txd) && lowCnt_ff > bitClks);
    c_unmapped: cover property (pready && pslverr);
    c_bufWrite: cover property (bufWr);
endmodule
bind serial_port_modes_async serial_port_asserts #(.BAUD_W(BAUD_W))
    asserts_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));

// ==== verif/serial_line_partner.sv ====
// Remote serial transceiver model on the line side
module serial_line_partner (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    // Start, data LSB first, stop; noisy flips one clock mid-bit
    task automatic sendFrame(input logic [8:0] bits, input int nBits,
                             input logic stopBit, input int bitClks,
                             input bit noisy);
        logic [10:0] fr;
        fr = {2'b11, bits[7:0], 1'b0};
        fr[9] = bits[8];
        fr[nBits + 1] = stopBit;
        for (int i = 0; i < nBits + 2; i++) begin
            for (int c = 0; c < bitClks; c++) begin
                @(posedge clk);
                rxd <= fr[i] ^ (noisy && i <= nBits && c == bitClks / 2);
            end
        end
        @(posedge clk);
        rxd <= 1'b1;
    endtask
    // Short low pulse that is no start bit
    task automatic glitch(input int n);
        @(posedge clk);
        rxd <= 1'b0;
        repeat (n) @(posedge clk);
        rxd <= 1'b1;
    endtask
    // Capture one frame from txd, sampling mid-bit
    task automatic grabFrame(input int nBits, input int bitClks,
                             output logic [8:0] bits, output logic stopBit);
        bits = 9'h000;
        while (txd !== 1'b0) begin
            @(posedge clk);
        end
        repeat (bitClks / 2) @(posedge clk);
        for (int i = 0; i < nBits; i++) begin
            repeat (bitClks) @(posedge clk);
            bits[i] = txd;
        end
        repeat (bitClks) @(posedge clk);
        stopBit = txd;
    endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the asynchronous serial port
`include "serial_port_map.svh"
`define CHK(nm, exp, got) begin \
    numChecks++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("BAD %s exp %h got %h", nm, exp, got); \
    end \
end
module tb import serial_port_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        txd;
    logic [31:0] rdata;
    logic        rerr;
    logic [8:0]  bits;
    logic        stopBit;
    int          failures = 0;
    int          numChecks = 0;
    always #2.5 clk = ~clk;
    serial_port_modes_async serial_port_modes_async_inst (.clk(clk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd));
    serial_line_partner partner (.clk(clk), .txd(txd), .rxd(rxd));
    // One bus transfer; answer lands in rdata and rerr
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic testReset;
        `CHK("txd", 1'b1, txd)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("unmapped", 1'b1, rerr)
        $display("test reset done");
    endtask
    // Transmit in modes one to three and both mode two rates
    task automatic testTx;
        logic [31:0] ctl[4] = '{32'h01, 32'h12, 32'h06, 32'h13};
        logic [7:0]  dat[4] = '{8'ha5, 8'h3c, 8'h0f, 8'hc3};
        int          bc[4] = '{16, 16, 32, 32};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `SP_BAUD_OFS, i == 3 ? 32'h1 : 32'h0);
            apb(1'b1, `SP_CTRL_OFS, ctl[i]);
            apb(1'b1, `SP_BUF_OFS, {24'h0, dat[i]});
            partner.grabFrame(i == 0 ? 8 : 9, bc[i], bits, stopBit);
            `CHK("txbits", {ctl[i][4] && i > 0, dat[i]}, bits)
            `CHK("txstop", 1'b1, stopBit)
            apb(1'b0, `SP_CTRL_OFS, 32'h0);
            `CHK("txdone", 1'b1, rdata[6])
            repeat (bc[i]) @(posedge clk);
        end
        $display("test tx done");
    endtask
    // Mode one: noise, lost frames, back-to-back frames
    task automatic testRx1;
        apb(1'b1, `SP_BAUD_OFS, 32'h0);
        apb(1'b1, `SP_CTRL_OFS, 32'h01);
        partner.sendFrame(9'h03c, 8, 1'b1, 16, 1'b1);
        partner.sendFrame(9'h0c3, 8, 1'b1, 16, 1'b0);
        apb(1'b0, `SP_CTRL_OFS, 32'h0);
        `CHK("rxflags", 2'b11, {rdata[7], rdata[5]})
        apb(1'b0, `SP_BUF_OFS, 32'h0);
        `CHK("rxbuf", 8'h3c, rdata[7:0])
        apb(1'b1, `SP_CTRL_OFS, 32'h08);
        partner.sendFrame(9'h055, 8, 1'b0, 16, 1'b0);
        partner.sendFrame(9'h0aa, 8, 1'b1, 16, 1'b0);
        apb(1'b0, `SP_BUF_OFS, 32'h0);
        `CHK("rxbuf", 8'haa, rdata[7:0])
        $display("test rx mode one done");
    endtask
    // Modes two and three: false start, filter, ninth bit
    task automatic testRx23;
        apb(1'b1, `SP_CTRL_OFS, 32'h0b);
        partner.glitch(4);
        repeat (32) @(posedge clk);
        partner.sendFrame(9'h096, 9, 1'b1, 16, 1'b0);
        repeat (16) @(posedge clk);
        partner.sendFrame(9'h169, 9, 1'b1, 16, 1'b1);
        repeat (16) @(posedge clk);
        apb(1'b0, `SP_CTRL_OFS, 32'h0);
        `CHK("rxflags", 2'b11, {rdata[7], rdata[5]})
        apb(1'b0, `SP_BUF_OFS, 32'h0);
        `CHK("rxbuf", 8'h69, rdata[7:0])
        apb(1'b1, `SP_CTRL_OFS, 32'h06);
        partner.sendFrame(9'h081, 9, 1'b1, 32, 1'b0);
        repeat (32) @(posedge clk);
        apb(1'b0, `SP_CTRL_OFS, 32'h0);
        `CHK("rxflags", 2'b10, {rdata[7], rdata[5]})
        apb(1'b0, `SP_BUF_OFS, 32'h0);
        `CHK("rxbuf", 8'h81, rdata[7:0])
        // Low stop after ninth 1: no new frame may start on it
        apb(1'b1, `SP_CTRL_OFS, 32'h06);
        partner.sendFrame(9'h1c3, 9, 1'b0, 32, 1'b0);
        repeat (64) @(posedge clk);
        apb(1'b0, `SP_CTRL_OFS, 32'h0);
        `CHK("rxbusy", 3'b011, {rdata[8], rdata[7], rdata[5]})
        $display("test rx modes two three done");
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        testReset();
        testTx();
        testRx1();
        testRx23();
        test_done();
    end
    // Watchdog against a hang
    initial begin
        #200000;
        failures++;
        test_done();
    end
endmodule
